// ---- design/spms_pkg.sv ----
// constants, field layouts and carrier types of the serial port block
package spms_pkg;

    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_PIN_CONFIG = 8'h0C;

    // control register fields
    localparam int unsigned CTL_IRQ_EN = 7;
    localparam int unsigned CTL_PORT_EN = 6;
    localparam int unsigned CTL_BIT_ORDER = 5;
    localparam int unsigned CTL_MASTER = 4;
    localparam int unsigned CTL_CLOCK_IDLE_POLARITY = 3;
    localparam int unsigned CTL_CLOCK_SAMPLE_PHASE = 2;
    localparam int unsigned CTL_RATE_HI = 1;
    localparam int unsigned CTL_RATE_LO = 0;

    // status register fields
    localparam int unsigned STA_DONE = 7;
    localparam int unsigned STA_COLLIDE = 6;
    localparam int unsigned STA_DOUBLE = 0;

    // pin configuration fields: directions, idle output levels, global enable
    localparam int unsigned PIN_MOSI_DIR = 0;
    localparam int unsigned PIN_MISO_DIR = 1;
    localparam int unsigned PIN_SCK_DIR = 2;
    localparam int unsigned PIN_SS_DIR = 3;
    localparam int unsigned PIN_MOSI_VAL = 4;
    localparam int unsigned PIN_MISO_VAL = 5;
    localparam int unsigned PIN_SCK_VAL = 6;
    localparam int unsigned PIN_SS_VAL = 7;
    localparam int unsigned PIN_GLOBAL_IRQ = 8;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [8:0] PIN_CONFIG_RESET = 9'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // half periods of the master serial clock, in system clocks
    localparam logic [6:0] HALF_DIV2 = 7'h01;
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV32 = 7'h10;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;

    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b01,
        MS_SHIFT = 2'b10
    } spms_mstate_t;

    typedef struct packed {
        logic mosi;
        logic miso;
        logic sck;
        logic ss_n;
    } spms_pins_in_t;

    typedef struct packed {
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
        logic sck;
        logic sck_oe;
        logic ss_n;
        logic ss_n_oe;
    } spms_pins_out_t;

    function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
        logic [6:0] h;
        h = HALF_DIV4;
        case ({dbl, rate})
            3'h0: h = HALF_DIV4;
            3'h1: h = HALF_DIV16;
            3'h2: h = HALF_DIV64;
            3'h3: h = HALF_DIV128;
            3'h4: h = HALF_DIV2;
            3'h5: h = HALF_DIV8;
            3'h6: h = HALF_DIV32;
            default: h = HALF_DIV64;
        endcase
        return h;
    endfunction

    function automatic logic out_pos(input logic lsb_first, input logic [7:0] v);
        return lsb_first ? v[0] : v[7];
    endfunction

endpackage

// ---- design/spms_port.sv ----
// byte-wide serial port, master or slave, with an AXI4-Lite register slave
`timescale 1ns/1ns
module spms_port (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire spms_pkg::spms_pins_in_t pins_in,
    output spms_pkg::spms_pins_out_t pins_out,
    input wire logic irq_ack_in,
    output logic irq_out
);
    import spms_pkg::*;

    logic [7:0] control;
    logic [8:0] pin_config;
    logic double_rate;
    logic transfer_done_flag;
    logic write_collision_flag;
    logic arm_done;
    logic arm_collide;
    logic [7:0] rx_buf;
    logic [7:0] shift_reg;
    logic out_bit;
    logic sck_level;
    logic sck_prev;
    logic [6:0] half_cnt;
    logic [6:0] m_half;
    logic [3:0] edge_idx;
    logic [3:0] bit_cnt;
    spms_mstate_t mstate;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    spms_pins_out_t next_pins;

    logic port_en;
    logic master;
    logic lsb_first;
    logic clock_idle_polarity;
    logic clock_sample_phase;
    logic wr_exec;
    logic rd_exec;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_pins;
    logic rd_stat;
    logic rd_data;
    logic data_access;
    logic busy;
    logic mode_fault;
    logic slave_active;
    logic m_tick;
    logic s_edge;
    logic lead;
    logic trail;
    logic sample_ev;
    logic setup_ev;
    logic in_bit;
    logic [7:0] shifted;
    logic done_ev;
    logic start_ev;
    logic collide_ev;

    assign port_en = control[CTL_PORT_EN];
    assign master = control[CTL_MASTER];
    assign lsb_first = control[CTL_BIT_ORDER];
    assign clock_idle_polarity = control[CTL_CLOCK_IDLE_POLARITY];
    assign clock_sample_phase = control[CTL_CLOCK_SAMPLE_PHASE];

    // a write runs once address and data are both held and no response is pending
    assign wr_exec = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
    assign rd_exec = s_axi_arvalid_in && s_axi_arready_out;
    assign wr_ctrl = wr_exec && aw_addr == OFS_CONTROL && w_strb[0];
    assign wr_stat = wr_exec && aw_addr == OFS_STATUS && w_strb[0];
    assign wr_data = wr_exec && aw_addr == OFS_DATA && w_strb[0];
    assign wr_pins = wr_exec && aw_addr == OFS_PIN_CONFIG;
    assign rd_stat = rd_exec && s_axi_araddr_in == OFS_STATUS;
    assign rd_data = rd_exec && s_axi_araddr_in == OFS_DATA;
    assign data_access = wr_data || rd_data;

    assign busy = mstate == MS_SHIFT || bit_cnt != 4'h0;
    // another master pulled our select input low
    assign mode_fault = port_en && master && !pin_config[PIN_SS_DIR]
        && !pins_in.ss_n;
    assign slave_active = port_en && !master && !pins_in.ss_n;

    assign m_tick = mstate == MS_SHIFT && half_cnt == 7'h00;
    assign s_edge = slave_active && pins_in.sck != sck_prev;
    // leading edge leaves the idle level, trailing edge returns to it
    always_comb begin
        if (master) begin
            lead = m_tick && !edge_idx[0];
            trail = m_tick && edge_idx[0];
        end else begin
            lead = s_edge && pins_in.sck != clock_idle_polarity;
            trail = s_edge && pins_in.sck == clock_idle_polarity;
        end
    end
    assign sample_ev = clock_sample_phase ? trail : lead;
    assign setup_ev = clock_sample_phase ? lead : trail;
    assign in_bit = master ? pins_in.miso : pins_in.mosi;
    assign shifted = lsb_first ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
    // master ends after the sixteenth edge, slave on its eighth sample
    assign done_ev = master ? (m_tick && edge_idx == LAST_EDGE)
        : (sample_ev && bit_cnt == LAST_BIT);
    assign start_ev = wr_data && !busy && port_en;
    assign collide_ev = wr_data && busy;

    // write channel acceptance
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                s_axi_awready_out <= 1'b0;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                s_axi_wready_out <= 1'b0;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (wr_exec) begin
                s_axi_bvalid_out <= 1'b1;
                if (aw_addr == OFS_CONTROL || aw_addr == OFS_STATUS
                    || aw_addr == OFS_DATA || aw_addr == OFS_PIN_CONFIG) begin
                    s_axi_bresp_out <= RESP_OKAY;
                end else begin
                    s_axi_bresp_out <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end else begin
            if (rd_exec) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= RESP_OKAY;
                if (s_axi_araddr_in == OFS_CONTROL) begin
                    s_axi_rdata_out <= {24'h00_0000, control};
                end else if (s_axi_araddr_in == OFS_STATUS) begin
                    // reserved bits read zero
                    s_axi_rdata_out <= {24'h00_0000, transfer_done_flag,
                        write_collision_flag, 5'h00, double_rate};
                end else if (s_axi_araddr_in == OFS_DATA) begin
                    s_axi_rdata_out <= {24'h00_0000, rx_buf};
                end else if (s_axi_araddr_in == OFS_PIN_CONFIG) begin
                    s_axi_rdata_out <= {23'h00_0000, pin_config};
                end else begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= RESP_SLVERR;
                end
            end
            if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    // software settings; hardware fault outranks a same-cycle write
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            control <= CONTROL_RESET;
            pin_config <= PIN_CONFIG_RESET;
            double_rate <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                control <= w_data[7:0];
            end
            if (mode_fault) begin
                control[CTL_MASTER] <= 1'b0;
            end
            if (wr_stat) begin
                double_rate <= w_data[STA_DOUBLE];
            end
            if (wr_pins && w_strb[0]) begin
                pin_config[7:0] <= w_data[7:0];
            end
            if (wr_pins && w_strb[1]) begin
                pin_config[PIN_GLOBAL_IRQ] <= w_data[PIN_GLOBAL_IRQ];
            end
        end
    end

    // sticky flags: a set in the same cycle beats any clear
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            transfer_done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            arm_done <= 1'b0;
            arm_collide <= 1'b0;
        end else begin
            if (done_ev || mode_fault) begin
                transfer_done_flag <= 1'b1;
            end else if (irq_ack_in || (data_access && (arm_done || arm_collide))) begin
                transfer_done_flag <= 1'b0;
            end
            if (collide_ev) begin
                write_collision_flag <= 1'b1;
            end else if (data_access && arm_collide) begin
                write_collision_flag <= 1'b0;
            end
            if (data_access) begin
                arm_done <= 1'b0;
                arm_collide <= 1'b0;
            end else if (rd_stat) begin
                arm_done <= transfer_done_flag;
                arm_collide <= write_collision_flag;
            end
        end
    end

    // master clock generator
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mstate <= MS_IDLE;
            half_cnt <= 7'h00;
            m_half <= HALF_DIV4;
            edge_idx <= 4'h0;
            sck_level <= 1'b0;
        end else begin
            case (mstate)
                MS_IDLE: begin
                    sck_level <= clock_idle_polarity;
                    edge_idx <= 4'h0;
                    if (start_ev && master) begin
                        // rate latched so a mid-byte change cannot tear the clock
                        m_half <= half_period(double_rate, control[1:0]);
                        half_cnt <= half_period(double_rate, control[1:0]) - 7'h01;
                        mstate <= MS_SHIFT;
                    end
                end
                MS_SHIFT: begin
                    if (!port_en || !master || mode_fault) begin
                        mstate <= MS_IDLE;
                    end else if (m_tick) begin
                        sck_level <= !sck_level;
                        edge_idx <= edge_idx + 4'h1;
                        half_cnt <= m_half - 7'h01;
                        if (edge_idx == LAST_EDGE) begin
                            mstate <= MS_IDLE;
                        end
                    end else begin
                        half_cnt <= half_cnt - 7'h01;
                    end
                end
                default: mstate <= MS_IDLE;
            endcase
        end
    end

    // shift register, bit counter and receive buffer
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            shift_reg <= DATA_RESET;
            rx_buf <= DATA_RESET;
            out_bit <= 1'b0;
            bit_cnt <= 4'h0;
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= pins_in.sck;
            if (start_ev) begin
                shift_reg <= w_data[7:0];
                out_bit <= out_pos(lsb_first, w_data[7:0]);
            end else if (!port_en || mode_fault || (!master && pins_in.ss_n)) begin
                // deselect drops any partial byte
                bit_cnt <= 4'h0;
                out_bit <= out_pos(lsb_first, shift_reg);
            end else begin
                if (sample_ev) begin
                    shift_reg <= shifted;
                    bit_cnt <= (bit_cnt == LAST_BIT) ? 4'h0 : bit_cnt + 4'h1;
                end
                if (setup_ev) begin
                    out_bit <= out_pos(lsb_first, shift_reg);
                end
                if (done_ev) begin
                    // an unread byte is overwritten here
                    rx_buf <= sample_ev ? shifted : shift_reg;
                    if (master) begin
                        bit_cnt <= 4'h0;
                    end
                end
            end
        end
    end

    // pin directions and levels
    always_comb begin
        next_pins.mosi = pin_config[PIN_MOSI_VAL];
        next_pins.mosi_oe = pin_config[PIN_MOSI_DIR];
        next_pins.miso = pin_config[PIN_MISO_VAL];
        next_pins.miso_oe = pin_config[PIN_MISO_DIR];
        next_pins.sck = pin_config[PIN_SCK_VAL];
        next_pins.sck_oe = pin_config[PIN_SCK_DIR];
        next_pins.ss_n = pin_config[PIN_SS_VAL];
        next_pins.ss_n_oe = pin_config[PIN_SS_DIR];
        if (port_en && master && !mode_fault) begin
            next_pins.mosi = out_bit;
            next_pins.sck = sck_level;
            next_pins.miso_oe = 1'b0;
        end else if (port_en) begin
            // slave role: only slave-out may drive
            next_pins.mosi_oe = 1'b0;
            next_pins.sck_oe = 1'b0;
            next_pins.ss_n_oe = 1'b0;
            if (slave_active) begin
                next_pins.miso = out_bit;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pins_out <= '0;
            irq_out <= 1'b0;
        end else begin
            pins_out <= next_pins;
            irq_out <= transfer_done_flag && control[CTL_IRQ_EN]
                && pin_config[PIN_GLOBAL_IRQ];
        end
    end

    // checks
    logic [10:0] m_cycles;
    logic rd_was_status;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            m_cycles <= 11'h000;
            rd_was_status <= 1'b0;
        end else begin
            m_cycles <= (mstate == MS_SHIFT) ? m_cycles + 11'h001 : 11'h000;
            if (rd_exec) begin
                rd_was_status <= rd_stat;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_fault_to_slave: assert property (mode_fault |=> !master && transfer_done_flag)
        else $error("mode fault did not force slave role and done flag");
    a_fault_sets_done: assert property (mode_fault ##1 1 |-> ##[0:1] transfer_done_flag)
        else $error("done flag missing after mode fault");
    a_deselect_reset: assert property ((port_en && !master && pins_in.ss_n) |=> bit_cnt == 4'h0)
        else $error("slave bit counter not cleared on deselect");
    a_disabled_idle: assert property (!port_en ##1 !port_en |-> mstate == MS_IDLE && bit_cnt == 4'h0)
        else $error("disabled port still shifting");
    a_master_length: assert property ((m_tick && edge_idx == LAST_EDGE)
        |-> m_cycles == {m_half, 4'h0} - 11'h001)
        else $error("master byte length does not match the rate");
    a_idle_polarity: assert property (mstate == MS_IDLE |=> sck_level == $past(clock_idle_polarity))
        else $error("idle serial clock level wrong");
    a_collide_set: assert property (collide_ev |=> write_collision_flag)
        else $error("collision flag not set");
    a_flag_clear: assert property ((data_access && arm_collide && !done_ev && !mode_fault
        && !collide_ev)
        |=> !write_collision_flag && !transfer_done_flag)
        else $error("status then data access did not clear flags");
    a_done_set: assert property (done_ev |=> transfer_done_flag)
        else $error("done flag not set at end of byte");
    a_reserved_zero: assert property ((s_axi_rvalid_out && rd_was_status) |-> s_axi_rdata_out[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    a_slave_pins: assert property ((port_en && !master) |=> !pins_out.mosi_oe && !pins_out.sck_oe
        && !pins_out.ss_n_oe)
        else $error("slave drives a pin that must be input");
    a_irq_request: assert property ((transfer_done_flag && control[CTL_IRQ_EN] && pin_config[PIN_GLOBAL_IRQ])
        ##1 transfer_done_flag |-> irq_out)
        else $error("interrupt request missing");

    c_master_byte: cover property (master && done_ev);
    c_slave_byte: cover property (!master && done_ev);
    c_mode_fault: cover property (mode_fault);
    c_collision: cover property (collide_ev);

endmodule

// ---- bench/spms_far_slave.sv ----
// far-side serial slave model, clock idle low, sample on rising edge, msb first
`timescale 1ns/1ns
module spms_far_slave (
    input wire logic clk_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic ss_n_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic sck_q;
    logic [2:0] cnt;
    initial begin
        sck_q = 1'b0;
        cnt = 3'h0;
        rx_out = 8'h00;
    end
    always @(posedge clk_in) begin
        sck_q <= sck_in;
        if (ss_n_in) begin
            cnt <= 3'h0;
        end else if (sck_in && !sck_q) begin
            rx_out <= {rx_out[6:0], mosi_in};
        end else if (!sck_in && sck_q) begin
            cnt <= cnt + 3'h1;
        end
    end
    // released line shows the inverse so a stale level never passes
    assign miso_out = ss_n_in ? ~tx_in[3'h7 - cnt] : tx_in[3'h7 - cnt];
endmodule

// ---- bench/testbench.sv ----
// self-checking bench: register bus tasks and serial transfers
`timescale 1ns/1ns
module testbench;
    import spms_pkg::*;
    logic clk_in, reset_n_in, awv, wv, bry, arv, rry, ack, ssd, miso_p, fsck, fmosi;
    logic [7:0] awa, ara, ptx, prx, fg;
    logic [31:0] wd, v;
    int bad_count, tests_run;
    wire logic awr, wrdy, bv, arr, rv, irq;
    wire logic [31:0] rdat;
    spms_pins_out_t po;
    spms_pins_in_t pi;
    // undriven mosi and sck come from the bench acting as far master
    assign pi = {po.mosi_oe ? po.mosi : fmosi, po.miso_oe ? po.miso : miso_p,
                 po.sck_oe ? po.sck : fsck, po.ss_n_oe ? po.ss_n : ssd};
    spms_port spms_port_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrdy), .s_axi_bresp_out(), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .pins_in(pi), .pins_out(po),
        .irq_ack_in(ack), .irq_out(irq));
    spms_far_slave spms_far_slave_inst (.clk_in(clk_in), .sck_in(pi.sck),
        .mosi_in(pi.mosi), .ss_n_in(pi.ss_n), .tx_in(ptx), .miso_out(miso_p), .rx_out(prx));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo;
        bad_count++;
        end_of_test();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_in);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        bry <= 1'b0;
        @(posedge clk_in);
        if (n == 64) tmo();
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_in);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        v = rdat;
        rry <= 1'b0;
        @(posedge clk_in);
        if (n == 64) tmo();
    endtask
    task automatic ckr(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask
    task automatic wdone;
        int n;
        v = 32'h0;
        for (n = 0; n < 200 && !v[STA_DONE]; n++) rd(OFS_STATUS);
        if (n == 200) tmo();
    endtask
    // far master, clock idle high, setup on falling, sample on rising, msb first
    task automatic fm(input logic [7:0] d, input int nb);
        int i;
        for (i = 0; i < nb; i++) begin
            fsck <= 1'b0;
            fmosi <= d[7 - i];
            repeat (4) @(posedge clk_in);
            fg = {fg[6:0], pi.miso};
            fsck <= 1'b1;
            repeat (4) @(posedge clk_in);
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        {reset_n_in, awv, wv, bry, arv, rry, ack, awa, ara, wd} = '0;
        {ssd, fmosi, fsck} = 3'b110;
        ptx = 8'h3A;
        bad_count = 0;
        tests_run = 0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        ckr(OFS_CONTROL, 32'h0);
        wr(OFS_STATUS, 32'hFF);
        ckr(OFS_STATUS, 32'h01);
        wr(OFS_STATUS, 32'h0);
        $display("test registers done");
        wr(OFS_PIN_CONFIG, 32'h10D);
        // rate code 01 keeps sck far below a quarter of the system clock
        wr(OFS_CONTROL, 32'hD1);
        wr(OFS_DATA, 32'hA5);
        wdone();
        chk(irq, 1);
        chk(prx, 8'hA5);
        ckr(OFS_DATA, 32'h3A);
        ckr(OFS_STATUS, 32'h0);
        $display("test transfer done");
        wr(OFS_DATA, 32'h55);
        wr(OFS_DATA, 32'hFF);
        ckr(OFS_STATUS, 32'h40);
        wdone();
        chk(v, 32'hC0);
        chk(prx, 8'h55);
        rd(OFS_DATA);
        ckr(OFS_STATUS, 32'h0);
        $display("test collision done");
        wr(OFS_CONTROL, 32'hF1);
        wr(OFS_DATA, 32'h01);
        wdone();
        chk(prx, 8'h80);
        ckr(OFS_DATA, 32'h5C);
        $display("test bit order done");
        wr(OFS_PIN_CONFIG, 32'h105);
        ssd <= 1'b0;
        ckr(OFS_CONTROL, 32'hE1);
        chk(po.mosi_oe, 0);
        chk(irq, 1);
        ack <= 1'b1;
        @(posedge clk_in);
        ack <= 1'b0;
        ckr(OFS_STATUS, 32'h0);
        $display("test mode fault done");
        {ssd, fsck} <= 2'b11;
        wr(OFS_PIN_CONFIG, 32'h102);
        wr(OFS_CONTROL, 32'hCC);
        wr(OFS_DATA, 32'hC3);
        ssd <= 1'b0;
        fm(8'h96, 8);
        chk(fg, 8'hC3);
        ckr(OFS_STATUS, 32'h80);
        ckr(OFS_DATA, 32'h96);
        fm(8'hFF, 3);
        ckr(OFS_STATUS, 32'h0);
        ssd <= 1'b1;
        repeat (2) @(posedge clk_in);
        ssd <= 1'b0;
        fm(8'h5A, 8);
        ckr(OFS_STATUS, 32'h80);
        ckr(OFS_DATA, 32'h5A);
        $display("test slave done");
        {ssd, fsck} <= 2'b10;
        wr(OFS_CONTROL, 32'hD1);
        wr(OFS_STATUS, 32'h01);
        wr(OFS_PIN_CONFIG, 32'h10D);
        wr(OFS_DATA, 32'h6C);
        wdone();
        chk(prx, 8'h6C);
        ckr(OFS_DATA, 32'h3A);
        $display("test double rate done");
        end_of_test();
    end
endmodule
